// file: rtl/flash_rom_pkg.sv
/*
  constants, field positions and types of the on-chip rom/flash front end.
  assumes one 25 MHz system clock and 8-bit registers on a 16-bit bus.
*/
`default_nettype none
package flash_rom_pkg;
  localparam logic [15:0] ADDR_FLASH_MODE_CONTROL    = 16'hff80;
  localparam logic [15:0] ADDR_FLASH_SETUP_AND_ERROR = 16'hff81;
  localparam logic [15:0] ADDR_ERASE_BLOCK_HIGH      = 16'hff82;
  localparam logic [15:0] ADDR_ERASE_BLOCK_LOW       = 16'hff83;
  localparam logic [15:0] ADDR_SERIAL_TIMER_CONTROL  = 16'hffc3;
  localparam logic [15:0] ADDR_MODE_CONTROL_REGISTER = 16'hffc5;
  localparam logic [7:0]  RST_FLASH_MODE_CONTROL     = 8'h80;
  localparam logic [7:0]  RST_SERIAL_TIMER_CONTROL   = 8'h00;
  // field positions
  localparam int BIT_SWE   = 6;
  localparam int BIT_EV    = 3;
  localparam int BIT_PV    = 2;
  localparam int BIT_ERASE = 1;
  localparam int BIT_PROG  = 0;
  localparam int BIT_ESU   = 1;
  localparam int BIT_PSU   = 0;
  localparam int BIT_FLASH_REGISTER_SELECT = 3;
  localparam int BIT_EXPANDED_MODE_ENABLE  = 7;
  // array geometry in 16-bit words; NORMAL_LIMIT is a byte address
  localparam int          PAGE_WORDS   = 16;
  localparam logic [16:0] NORMAL_LIMIT = 17'h0e000;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam int          BLOCKS       = 10;
  localparam logic [15:0] BLOCK_FIRST [BLOCKS] = '{16'h0000, 16'h0200,
    16'h0400, 16'h0600, 16'h0800, 16'h4000, 16'h6000, 16'h7000,
    16'h8000, 16'hc000};
  localparam logic [15:0] BLOCK_LAST [BLOCKS] = '{16'h01ff, 16'h03ff,
    16'h05ff, 16'h07ff, 16'h3fff, 16'h5fff, 16'h6fff, 16'h7fff,
    16'hbfff, 16'hffff};
  // sub-mode codes on the three boot select pins
  localparam logic [2:0] BOOT_SEL_BOOT       = 3'h1;
  localparam logic [2:0] BOOT_SEL_USER_PROG  = 3'h2;
  localparam logic [2:0] BOOT_SEL_PROGRAMMER = 3'h4;
  // autobaud: host sends a zero byte, start bit plus eight low bits
  localparam logic [15:0] AUTOBAUD_LOW_BITS = 16'h0009;
  localparam int          REG_STATES        = 2;

  typedef enum logic [2:0] {MODE_1, MODE_2, MODE_3, MODE_BOOT,
    MODE_USER_PROG, MODE_PROGRAMMER, MODE_USER} op_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} op_state_t;
endpackage
`default_nettype wire

// file: rtl/flash_word_array.sv
/*
  flash array storage, 64k words of 16 bits, one port.
  assumes the caller owns arbitration; read data leave a register, and a
  bypass word can be loaded into that register instead of the array word.
*/
`default_nettype none
module flash_word_array
(
  input  wire logic        clk_sys,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        bypass,
  input  wire logic [15:0] bypass_data,
  output var  logic [15:0] rdata
);
  logic [15:0] mem [65536];

  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= bypass ? bypass_data : mem[addr];
  end
endmodule // flash_word_array
`default_nettype wire

// file: rtl/flash_rom_access.sv
/*
  rom/flash access front end: array reads, page programming, block erase,
  flash control registers, mode latch and boot autobaud.
  assumes synchronous inputs, one request per acknowledge, bus_req a pulse.
*/
//
// Function
// - byte and word reads in one state
// - even address upper lane, odd lower
// - pins 0,1: normal, expanded, array disabled
// - pins 1,0: advanced, array on, expanded_mode_enable selects
// - normal addressing limits array to 56 kbytes
// - latch mode pins at reset, enter mode
// - pins 0,0: boot select pins pick mode
// - user mode reads only, no program/erase
// - four modes: program, erase, both verifies
// - program 32 bytes per operation
// - ten erase blocks of documented sizes
// - boot mode erases whole array to ones
// - user program mode erases per block only
// - boot serial rate adapts to host
// - hardware, software and error protection
// - flash registers selected by serial_timer_control bit
// - flash disabled: registers read zero, ignore writes
// - swe clear holds register two, blocks zero
// - control registers byte only, two states
// - mask variant: undefined reads, writes ignored
// - mode 1 forces expanded_mode_enable; else resets 0
`default_nettype none
module flash_rom_access
#(
  parameter bit         FLASH_VARIANT = 1'b1,
  parameter logic [7:0] UNDEF_VALUE   = 8'h00
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        mode_pin_high,
  input  wire logic        mode_pin_low,
  input  wire logic        boot_select_pin_2,
  input  wire logic        boot_select_pin_1,
  input  wire logic        boot_select_pin_0,
  input  wire logic        bus_req,
  input  wire logic        bus_reg,
  input  wire logic        bus_write,
  input  wire logic        bus_word,
  input  wire logic [16:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  output var  logic        bus_ack,
  output var  logic [15:0] bus_rdata,
  output var  logic        ext_req,
  output var  logic        array_enabled,
  output var  logic        cpu_advanced,
  output var  logic        expanded,
  input  wire logic        serial_receive_pin,
  output var  logic        serial_transmit_pin,
  output var  logic        serial_rate_locked,
  output var  logic [15:0] serial_bit_period
);
  typedef struct packed {
    logic                        captured;
    flash_rom_pkg::op_mode_t     mode;
    logic [1:0]                  pins;
    logic                        expanded_mode_enable;
    logic [7:0]                  serial_timer_control;
    logic                        software_write_enable;
    logic                        ev;
    logic                        pv;
    logic                        erase;
    logic                        prog;
    logic                        fler;
    logic                        esu;
    logic                        psu;
    logic [9:0]                  eb;
    flash_rom_pkg::op_state_t    op;
    logic [15:0]                 cnt;
    logic [15:0]                 last;
    logic [11:0]                 pbase;
    logic [15:0][15:0]           page;
    logic                        ack;
    logic                        ext;
    logic                        reg_wait;
    logic [15:0]                 raddr;
    logic                        rwrite;
    logic                        rword;
    logic [7:0]                  rwdata;
    logic                        rx_prev;
    logic                        locked;
    logic [15:0]                 baud_cnt;
    logic [15:0]                 period;
  } state_t;

  state_t      s;
  state_t      next_s;
  logic        mem_we;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic        bypass;
  logic [15:0] bypass_data;
  logic        accept;
  logic        pe_ok;
  logic        flash_regs;
  logic [7:0]  rd;
  logic [7:0]  wv;

  function automatic logic pe_allowed(flash_rom_pkg::op_mode_t m);
    return m == flash_rom_pkg::MODE_BOOT ||
           m == flash_rom_pkg::MODE_USER_PROG ||
           m == flash_rom_pkg::MODE_PROGRAMMER;
  endfunction

  function automatic logic in_array(flash_rom_pkg::op_mode_t m,
                                    logic [16:0] a);
    if (m == flash_rom_pkg::MODE_1)
    begin
      return 1'b0;
    end
    if (m == flash_rom_pkg::MODE_3)
    begin
      return a < flash_rom_pkg::NORMAL_LIMIT;
    end
    return 1'b1;
  endfunction

  function automatic logic onehot10(logic [9:0] v);
    return v != 10'h000 && (v & (v - 10'h001)) == 10'h000;
  endfunction

  assign accept = bus_req && s.captured && !s.reg_wait;
  // error protection and hardware protection both gate program/erase
  assign pe_ok = pe_allowed(s.mode) && !s.fler;
  // shared addresses belong to other registers unless the select bit is set
  assign flash_regs = s.serial_timer_control[flash_rom_pkg::BIT_FLASH_REGISTER_SELECT];

  always_comb
  begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.ext = 1'b0;
    mem_we = 1'b0;
    mem_addr = bus_addr[16:1];
    mem_wdata = flash_rom_pkg::ERASED_WORD;
    bypass = 1'b0;
    bypass_data = 16'h0000;
    rd = 8'h00;
    wv = s.rwdata;
    if (!s.captured)
    begin
      // pins are taken on the first edge after release
      next_s.captured = 1'b1;
      next_s.pins = {mode_pin_high, mode_pin_low};
      case ({mode_pin_high, mode_pin_low})
        2'b01: next_s.mode = flash_rom_pkg::MODE_1;
        2'b10: next_s.mode = flash_rom_pkg::MODE_2;
        2'b11: next_s.mode = flash_rom_pkg::MODE_3;
        default:
          case ({boot_select_pin_2, boot_select_pin_1, boot_select_pin_0})
            flash_rom_pkg::BOOT_SEL_BOOT:
              next_s.mode = flash_rom_pkg::MODE_BOOT;
            flash_rom_pkg::BOOT_SEL_USER_PROG:
              next_s.mode = flash_rom_pkg::MODE_USER_PROG;
            flash_rom_pkg::BOOT_SEL_PROGRAMMER:
              next_s.mode = flash_rom_pkg::MODE_PROGRAMMER;
            default: next_s.mode = flash_rom_pkg::MODE_USER;
          endcase
      endcase
      next_s.expanded_mode_enable = {mode_pin_high, mode_pin_low} == 2'b01;
    end
    // register reads and writes finish in the second state
    if (s.reg_wait)
    begin
      next_s.reg_wait = 1'b0;
      next_s.ack = 1'b1;
      case (s.raddr)
        flash_rom_pkg::ADDR_FLASH_MODE_CONTROL:
          rd = {1'b1, s.software_write_enable, 2'b00, s.ev, s.pv, s.erase, s.prog};
        flash_rom_pkg::ADDR_FLASH_SETUP_AND_ERROR:
          rd = s.software_write_enable ? {s.fler, 5'h00, s.esu, s.psu} : 8'h00;
        flash_rom_pkg::ADDR_ERASE_BLOCK_HIGH:
          rd = s.software_write_enable ? {6'h00, s.eb[9:8]} : 8'h00;
        flash_rom_pkg::ADDR_ERASE_BLOCK_LOW:
          rd = s.software_write_enable ? s.eb[7:0] : 8'h00;
        flash_rom_pkg::ADDR_SERIAL_TIMER_CONTROL: rd = s.serial_timer_control;
        flash_rom_pkg::ADDR_MODE_CONTROL_REGISTER:
          rd = {s.expanded_mode_enable, 5'h00, s.pins};
        default: rd = 8'h00;
      endcase
      if (s.raddr[15:2] == flash_rom_pkg::ADDR_FLASH_MODE_CONTROL[15:2])
      begin
        if (!flash_regs)
        begin
          rd = 8'h00;
        end
        else if (!FLASH_VARIANT)
        begin
          rd = UNDEF_VALUE;
        end
        else if (s.mode == flash_rom_pkg::MODE_1)
        begin
          rd = 8'h00;
        end
      end
      if (s.rword)
      begin
        rd = 8'h00;
      end
      bypass = 1'b1;
      bypass_data = s.raddr[0] ? {8'h00, rd} : {rd, 8'h00};
      if (s.rwrite && !s.rword)
      begin
        case (s.raddr)
          flash_rom_pkg::ADDR_SERIAL_TIMER_CONTROL: next_s.serial_timer_control = wv;
          flash_rom_pkg::ADDR_MODE_CONTROL_REGISTER:
            if (s.mode != flash_rom_pkg::MODE_1)
            begin
              next_s.expanded_mode_enable = wv[flash_rom_pkg::BIT_EXPANDED_MODE_ENABLE];
            end
          default: ;
        endcase
        if (flash_regs && FLASH_VARIANT &&
            s.mode != flash_rom_pkg::MODE_1)
        begin
          case (s.raddr)
            flash_rom_pkg::ADDR_FLASH_MODE_CONTROL:
            begin
              next_s.software_write_enable = wv[flash_rom_pkg::BIT_SWE];
              // the four flash modes, each gated by its setting condition
              next_s.ev = s.software_write_enable & wv[flash_rom_pkg::BIT_EV];
              next_s.pv = s.software_write_enable & wv[flash_rom_pkg::BIT_PV];
              next_s.erase = s.software_write_enable & s.esu & pe_ok &
                             wv[flash_rom_pkg::BIT_ERASE];
              next_s.prog = s.software_write_enable & s.psu & pe_ok &
                            wv[flash_rom_pkg::BIT_PROG];
            end
            flash_rom_pkg::ADDR_FLASH_SETUP_AND_ERROR:
            begin
              next_s.esu = s.software_write_enable & pe_ok & wv[flash_rom_pkg::BIT_ESU];
              next_s.psu = s.software_write_enable & pe_ok & wv[flash_rom_pkg::BIT_PSU];
            end
            flash_rom_pkg::ADDR_ERASE_BLOCK_HIGH:
              if (s.software_write_enable && s.mode != flash_rom_pkg::MODE_3)
              begin
                next_s.eb[9:8] = wv[1:0];
              end
            flash_rom_pkg::ADDR_ERASE_BLOCK_LOW:
              if (s.software_write_enable)
              begin
                next_s.eb[7:0] = wv;
              end
            default: ;
          endcase
        end
      end
    end
    else if (accept && bus_reg)
    begin
      next_s.reg_wait = 1'b1;
      next_s.raddr = bus_addr[15:0];
      next_s.rwrite = bus_write;
      next_s.rword = bus_word;
      next_s.rwdata = bus_addr[0] ? bus_wdata[7:0] : bus_wdata[15:8];
    end
    else if (accept && !in_array(s.mode, bus_addr))
    begin
      if (s.expanded_mode_enable)
      begin
        next_s.ext = 1'b1;
      end
      else
      begin
        next_s.ack = 1'b1;
        bypass = 1'b1;
      end
    end
    else if (accept)
    begin
      // whole word each state; the master picks its byte lane
      next_s.ack = 1'b1;
      if (s.op != flash_rom_pkg::ST_IDLE || s.erase || s.prog)
      begin
        // touching the array mid-operation trips error protection
        bypass = 1'b1;
        if (pe_allowed(s.mode))
        begin
          next_s.fler = 1'b1;
        end
      end
      else if (bus_write && s.software_write_enable && pe_ok)
      begin
        // writes fill the 32-byte page latch, never the array itself
        next_s.pbase = bus_addr[16:5];
        if (bus_word || !bus_addr[0])
        begin
          next_s.page[bus_addr[4:1]][15:8] = bus_wdata[15:8];
        end
        if (bus_word || bus_addr[0])
        begin
          next_s.page[bus_addr[4:1]][7:0] = bus_wdata[7:0];
        end
      end
    end
    case (s.op)
      flash_rom_pkg::ST_IDLE:
        if (next_s.erase && !s.erase)
        begin
          if (s.mode == flash_rom_pkg::MODE_BOOT)
          begin
            next_s.op = flash_rom_pkg::ST_ERASE;
            next_s.cnt = 16'h0000;
            next_s.last = 16'hffff;
          end
          else if (onehot10(s.eb))
          begin
            // only a single selected block, never a byte
            next_s.op = flash_rom_pkg::ST_ERASE;
            for (int i = 0; i < flash_rom_pkg::BLOCKS; i++)
            begin
              if (s.eb[i])
              begin
                next_s.cnt = flash_rom_pkg::BLOCK_FIRST[i];
                next_s.last = flash_rom_pkg::BLOCK_LAST[i];
              end
            end
          end
          else
          begin
            next_s.fler = 1'b1;
          end
        end
        else if (next_s.prog && !s.prog)
        begin
          next_s.op = flash_rom_pkg::ST_PROG;
          next_s.cnt = 16'h0000;
        end
      flash_rom_pkg::ST_ERASE:
      begin
        mem_we = 1'b1;
        mem_addr = s.cnt;
        next_s.cnt = s.cnt + 16'h0001;
        if (s.cnt == s.last)
        begin
          next_s.op = flash_rom_pkg::ST_IDLE;
        end
      end
      flash_rom_pkg::ST_PROG:
      begin
        // writes the latched words over the target page, erased or not
        mem_we = 1'b1;
        mem_addr = {s.pbase, s.cnt[3:0]};
        mem_wdata = s.page[s.cnt[3:0]];
        next_s.cnt = s.cnt + 16'h0001;
        if (s.cnt[3:0] == 4'hf)
        begin
          next_s.op = flash_rom_pkg::ST_IDLE;
          next_s.page = '1;
        end
      end
      default: next_s.op = flash_rom_pkg::ST_IDLE;
    endcase
    if (next_s.fler)
    begin
      next_s.op = flash_rom_pkg::ST_IDLE;
      next_s.erase = 1'b0;
      next_s.prog = 1'b0;
    end
    if (!next_s.software_write_enable)
    begin
      next_s.esu = 1'b0;
      next_s.psu = 1'b0;
      next_s.eb = 10'h000;
      next_s.ev = 1'b0;
      next_s.pv = 1'b0;
      next_s.erase = 1'b0;
      next_s.prog = 1'b0;
    end
    // measure the host's zero byte once, in boot mode only
    next_s.rx_prev = serial_receive_pin;
    if (s.mode == flash_rom_pkg::MODE_BOOT && !s.locked)
    begin
      if (!serial_receive_pin)
      begin
        next_s.baud_cnt = s.baud_cnt + 16'h0001;
      end
      else if (!s.rx_prev && s.baud_cnt != 16'h0000)
      begin
        next_s.period = s.baud_cnt / flash_rom_pkg::AUTOBAUD_LOW_BITS;
        next_s.locked = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.mode <= flash_rom_pkg::MODE_USER;
      s.serial_timer_control <= flash_rom_pkg::RST_SERIAL_TIMER_CONTROL;
      s.page <= '1;
      s.rx_prev <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  flash_word_array u_array
  (
    .clk_sys     (clk_sys),
    .we          (mem_we),
    .addr        (mem_addr),
    .wdata       (mem_wdata),
    .bypass      (bypass),
    .bypass_data (bypass_data),
    .rdata       (bus_rdata)
  );

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_ack <= 1'b0;
      ext_req <= 1'b0;
      array_enabled <= 1'b0;
      cpu_advanced <= 1'b0;
      expanded <= 1'b0;
      serial_transmit_pin <= 1'b1;
      serial_rate_locked <= 1'b0;
      serial_bit_period <= 16'h0000;
    end
    else
    begin
      bus_ack <= next_s.ack;
      ext_req <= next_s.ext;
      array_enabled <= next_s.captured &&
                       next_s.mode != flash_rom_pkg::MODE_1;
      cpu_advanced <= next_s.captured &&
                      next_s.mode != flash_rom_pkg::MODE_1 &&
                      next_s.mode != flash_rom_pkg::MODE_3;
      expanded <= next_s.expanded_mode_enable;
      serial_transmit_pin <= 1'b1;
      serial_rate_locked <= next_s.locked;
      serial_bit_period <= next_s.period;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence reg_req;
    accept && bus_reg;
  endsequence
  sequence prog_run;
    (s.op == flash_rom_pkg::ST_PROG)[*8] ##1
    (s.op == flash_rom_pkg::ST_PROG)[*8];
  endsequence

  a_reg_two_states: assert property (reg_req |-> !bus_ack ##1 !bus_ack
    ##1 bus_ack) else $error("register access not two states");
  a_array_one_state: assert property (accept && !bus_reg &&
    in_array(s.mode, bus_addr) |=> bus_ack)
    else $error("array access not one state");
  a_mode1_expanded_mode_enable: assert property (s.captured &&
    s.mode == flash_rom_pkg::MODE_1 |-> s.expanded_mode_enable)
    else $error("expanded_mode_enable not forced in mode 1");
  a_swe_holds_zero: assert property (!s.software_write_enable |-> s.eb == 10'h000 &&
    !s.esu && !s.psu) else $error("bits set with swe clear");
  a_user_no_pe: assert property (!pe_allowed(s.mode) |->
    s.op == flash_rom_pkg::ST_IDLE && !s.erase && !s.prog)
    else $error("program or erase outside allowed mode");
  a_page_sixteen: assert property ($rose(s.op == flash_rom_pkg::ST_PROG)
    |-> prog_run ##1 s.op != flash_rom_pkg::ST_PROG)
    else $error("page program not 16 words");
  a_disabled_regs: assert property ((reg_req and (!bus_write &&
    s.mode == flash_rom_pkg::MODE_1 &&
    bus_addr[15:2] == flash_rom_pkg::ADDR_FLASH_MODE_CONTROL[15:2]))
    |-> ##2 bus_rdata == 16'h0000)
    else $error("disabled flash register not zero");
  a_boot_whole: assert property ($rose(s.op == flash_rom_pkg::ST_ERASE)
    && s.mode == flash_rom_pkg::MODE_BOOT |-> s.cnt == 16'h0000 &&
    s.last == 16'hffff) else $error("boot erase not whole");
  a_mode_latched: assert property (s.captured |=> $stable(s.mode))
    else $error("mode changed after start");
endmodule // flash_rom_access
`default_nettype wire

// file: test/cpu_bus_model.sv
/*
  bus master model that faces the flash front end on the 16-bit bus.
  assumes its caller starts each access from a falling clock edge.
*/
`default_nettype none
module cpu_bus_model
(
  input  wire logic        clk_sys,
  input  wire logic        bus_ack,
  input  wire logic        ext_req,
  input  wire logic [15:0] bus_rdata,
  output var  logic        bus_req,
  output var  logic        bus_reg,
  output var  logic        bus_write,
  output var  logic        bus_word,
  output var  logic [16:0] bus_addr,
  output var  logic [15:0] bus_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
    {bus_req, bus_reg, bus_write, bus_word, bus_addr, bus_wdata} = '0;

  // request is a one-cycle pulse; qualifiers hold until the answer
  task automatic access(input logic r, w, wd, input logic [16:0] a,
                        input logic [15:0] d, output int lat,
                        output logic x, output logic [15:0] q);
    // lat counts edges from the taking edge to the one showing the answer
    lat = 1;
    @(negedge clk_sys);
    bus_reg = r;
    bus_write = w;
    bus_word = wd;
    bus_addr = wd ? {a[16:1], 1'b0} : a;
    bus_wdata = d;
    bus_req = 1'b1;
    @(negedge clk_sys);
    bus_req = 1'b0;
    while (bus_ack !== 1'b1 && ext_req !== 1'b1 && lat < 500)
    begin
      lat++;
      @(negedge clk_sys);
    end
    // read data is a memory register that reloads after the answer
    x = ext_req;
    q = bus_rdata;
    @(posedge clk_sys);
    @(negedge clk_sys);
    // released lines must not keep looking valid
    bus_addr = ~bus_addr;
    bus_wdata = ~bus_wdata;
  endtask
endmodule // cpu_bus_model
`default_nettype wire

// file: test/test_flash_rom_access.sv
/*
  self-checking bench: mode table, flash registers, page program,
  block erase, routing and boot rate measure.
  assumes the package, the design and the bus model compile first.
*/
`default_nettype none
module test_flash_rom_access;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0] p;
    logic [2:0] o;
    logic [7:0] f;
  } row_t;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        rx = 1'b1;
  logic [4:0]  pins = '0;
  logic        bus_req, bus_reg, bus_write, bus_word, bus_ack, ext_req;
  logic        array_enabled, cpu_advanced, expanded, locked;
  logic [16:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, period;
  logic [2:0]  outs;
  int          num_errors = 0;
  int          compares = 0;
  // pins {high, low, sel2, sel1, sel0}; outs {array, advanced, expanded}
  row_t        rows [7] = '{'{5'h08, 3'h1, 8'h00}, '{5'h10, 3'h6, 8'h80},
    '{5'h18, 3'h4, 8'h80}, '{5'h01, 3'h6, 8'h80}, '{5'h02, 3'h6, 8'h80},
    '{5'h04, 3'h6, 8'h80}, '{5'h00, 3'h6, 8'h80}};

  assign outs = {array_enabled, cpu_advanced, expanded};
  always #20 clk_sys = ~clk_sys;

  cpu_bus_model bm (.clk_sys(clk_sys), .bus_ack(bus_ack),
    .ext_req(ext_req), .bus_rdata(bus_rdata), .bus_req(bus_req),
    .bus_reg(bus_reg), .bus_write(bus_write), .bus_word(bus_word),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata));

  flash_rom_access DUT (.clk_sys(clk_sys), .rst_b(rst_b),
    .mode_pin_high(pins[4]), .mode_pin_low(pins[3]),
    .boot_select_pin_2(pins[2]), .boot_select_pin_1(pins[1]),
    .boot_select_pin_0(pins[0]), .bus_req(bus_req), .bus_reg(bus_reg),
    .bus_write(bus_write), .bus_word(bus_word), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .ext_req(ext_req), .array_enabled(array_enabled),
    .cpu_advanced(cpu_advanced), .expanded(expanded),
    .serial_receive_pin(rx), .serial_transmit_pin(),
    .serial_rate_locked(locked), .serial_bit_period(period));

  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rs(input logic [4:0] p);
    @(negedge clk_sys);
    rst_b = 1'b0;
    pins = p;
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] b);
    int          l;
    logic        x;
    logic [15:0] q;
    bm.access(1'b1, 1'b1, 1'b0, {1'b0, a}, {b, b}, l, x, q);
  endtask

  task automatic rr(input logic [15:0] a, input logic [7:0] b);
    int          l;
    logic        x;
    logic [15:0] q;
    bm.access(1'b1, 1'b0, 1'b0, {1'b0, a}, 16'h0000, l, x, q);
    chk("reg_states", 16'h0002, 16'(l));
    chk("reg_data", a[0] ? {8'h00, b} : {b, 8'h00}, q);
  endtask

  task automatic ra(input logic [16:0] a, input logic wd,
                    input logic [15:0] e, m, input logic x);
    int          l;
    logic        s;
    logic [15:0] q;
    bm.access(1'b0, 1'b0, wd, a, 16'h0000, l, s, q);
    chk("ext_req", 16'(x), 16'(s));
    if (!x)
    begin
      chk("array_states", 16'h0001, 16'(l));
      chk("array_data", e & m, q & m);
    end
  endtask

  initial
  begin
    int          l;
    logic        x;
    logic [16:0] a;
    logic [15:0] q;
    foreach (rows[i])
    begin
      rs(rows[i].p);
      chk("mode_outs", 16'(rows[i].o), 16'(outs));
      rr(16'hffc5, {rows[i].o[0], 5'h00, rows[i].p[4:3]});
      wr(16'hffc3, 8'h08);
      rr(16'hff80, rows[i].f);
      wr(16'hffc5, 8'h00);
      chk("expanded", 16'(rows[i].o[0]), 16'(expanded));
      $display("mode row %0d done", i);
    end
    rs(5'h02);
    rr(16'hff80, 8'h00);
    wr(16'hffc3, 8'h08);
    rr(16'hffc3, 8'h08);
    rr(16'hff81, 8'h00);
    rr(16'hff82, 8'h00);
    bm.access(1'b1, 1'b0, 1'b1, 17'h0ff80, 16'h0000, l, x, q);
    chk("word_reg", 16'h0000, q);
    wr(16'hff83, 8'h01);
    rr(16'hff83, 8'h00);
    wr(16'hff80, 8'h40);
    rr(16'hff80, 8'hc0);
    wr(16'hff83, 8'h01);
    rr(16'hff83, 8'h01);
    wr(16'hff80, 8'h00);
    rr(16'hff83, 8'h00);
    wr(16'hff80, 8'h40);
    for (int i = 0; i < 16; i++)
      bm.access(1'b0, 1'b1, 1'b1, 17'h00400 + 17'(2 * i),
                16'h1234 + 16'(i), l, x, q);
    wr(16'hff81, 8'h01);
    wr(16'hff80, 8'h41);
    repeat (24) @(negedge clk_sys);
    wr(16'hff80, 8'h40);
    wr(16'hff81, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      a = 17'h00400 + 17'(2 * i);
      ra(a, 1'b1, 16'h1234 + 16'(i), 16'hffff, 1'b0);
    end
    ra(17'h00403, 1'b0, 16'h0035, 16'h00ff, 1'b0);
    ra(17'h00402, 1'b0, 16'h1200, 16'hff00, 1'b0);
    $display("program test done");
    wr(16'hff81, 8'h02);
    wr(16'hff83, 8'h01);
    wr(16'hff80, 8'h42);
    repeat (540) @(negedge clk_sys);
    wr(16'hff80, 8'h40);
    wr(16'hff81, 8'h00);
    ra(17'h00000, 1'b1, 16'hffff, 16'hffff, 1'b0);
    ra(17'h003fe, 1'b1, 16'hffff, 16'hffff, 1'b0);
    ra(17'h00400, 1'b1, 16'h1234, 16'hffff, 1'b0);
    $display("erase test done");
    rs(5'h18);
    ra(17'h0e000, 1'b0, 16'h0000, 16'hffff, 1'b0);
    ra(17'h0dffe, 1'b1, 16'h0000, 16'h0000, 1'b0);
    wr(16'hffc5, 8'h80);
    chk("expanded", 16'h0001, 16'(expanded));
    ra(17'h0e000, 1'b0, 16'h0000, 16'h0000, 1'b1);
    rs(5'h08);
    ra(17'h00000, 1'b1, 16'h0000, 16'h0000, 1'b1);
    $display("routing test done");
    rs(5'h01);
    rx = 1'b0;
    repeat (180) @(negedge clk_sys);
    rx = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("rate_locked", 16'h0001, 16'(locked));
    chk("bit_period", 16'h0014, period);
    $display("autobaud test done");
    rs(5'h00);
    wr(16'hffc3, 8'h08);
    wr(16'hff80, 8'h40);
    wr(16'hff81, 8'h01);
    rr(16'hff81, 8'h00);
    $display("user mode test done");
    print_verdict();
  end

  initial
  begin
    repeat (4000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
endmodule // test_flash_rom_access
`default_nettype wire
